// ==== cis_cfg.svh ====
`ifndef CIS_CFG_SVH
`define CIS_CFG_SVH

// Link defaults
`define CIS_ACQ_DEF 8'h10
`define CIS_OS_DEF 9'h010
`define CIS_SAMPLE_W 20
`define CIS_RESULT_W 24
`define CIS_FS_CODE 24'h08_0000

// Clock and shortest integration
`define CIS_CLK_HZ 20000000
`define CIS_MIN_UNI_US 64
`define CIS_MIN_BIP_US 32
`define CIS_MIN_UNI_CLK ((`CIS_MIN_UNI_US * `CIS_CLK_HZ + 999999) / 1000000)
`define CIS_MIN_BIP_CLK ((`CIS_MIN_BIP_US * `CIS_CLK_HZ + 999999) / 1000000)

// Controller register offsets
`define CIS_CTRL_OFS 12'h000
`define CIS_CFG_OFS 12'h004
`define CIS_PERIOD_OFS 12'h008
`define CIS_PULSE_OFS 12'h00C
`define CIS_STATUS_OFS 12'h010
`define CIS_RESULT_OFS 12'h014

// Control fields
`define CIS_CTRL_RUN 0
`define CIS_CTRL_CONT 1
`define CIS_CTRL_CDS 2
`define CIS_CTRL_BIP 3
`define CIS_CTRL_TWOS 4
`define CIS_CFG_ACQ_LSB 0
`define CIS_CFG_OS_LSB 16
`define CIS_STAT_READY 0
`define CIS_STAT_FDS 1

// Reset values
`define CIS_PERIOD_RST 24'h00_2710
`define CIS_PULSE_RST 16'h0004

`endif

// ==== cis_controller.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cis_cfg.svh"
module cis_controller
    import cis_pkg::*;
#(
    parameter int RW = `CIS_RESULT_W
)
(
    input wire logic pclk,
    input wire logic presetn,
    cis_link_if.controller link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    if (RW > 32)
    begin : g_bad_width
        $error("Result wider than bus");
    end

    //--------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------
    logic [4:0] ctrl_r;
    logic [7:0] acq_r;
    logic [8:0] os_r;
    logic [23:0] period_r;
    logic [15:0] pulse_r;
    logic ready_r;
    logic [RW-1:0] result_r;
    logic wr;
    logic rd;
    logic hit;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign hit = (paddr == `CIS_CTRL_OFS) || (paddr == `CIS_CFG_OFS)
        || (paddr == `CIS_PERIOD_OFS) || (paddr == `CIS_PULSE_OFS)
        || (paddr == `CIS_STATUS_OFS) || (paddr == `CIS_RESULT_OFS);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= 5'h00;
            acq_r <= `CIS_ACQ_DEF;
            os_r <= `CIS_OS_DEF;
            period_r <= `CIS_PERIOD_RST;
            pulse_r <= `CIS_PULSE_RST;
        end
        else if (wr)
        begin
            case (paddr)
                `CIS_CTRL_OFS: ctrl_r <= pwdata[4:0];
                `CIS_CFG_OFS:
                begin
                    acq_r <= pwdata[`CIS_CFG_ACQ_LSB +: 8];
                    os_r <= pwdata[`CIS_CFG_OS_LSB +: 9];
                end
                `CIS_PERIOD_OFS: period_r <= pwdata[23:0];
                `CIS_PULSE_OFS: pulse_r <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Result capture; a new result wins over a clearing read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ready_r <= 1'b0;
            result_r <= '0;
        end
        else if (link.result_valid)
        begin
            ready_r <= 1'b1;
            result_r <= link.result;
        end
        else if (rd && (paddr == `CIS_RESULT_OFS))
        begin
            ready_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite)
            begin
                case (paddr)
                    `CIS_CTRL_OFS: prdata <= {27'h000_0000, ctrl_r};
                    `CIS_CFG_OFS: prdata <= {7'h00, os_r, 8'h00, acq_r};
                    `CIS_PERIOD_OFS: prdata <= {8'h00, period_r};
                    `CIS_PULSE_OFS: prdata <= {16'h0000, pulse_r};
                    `CIS_STATUS_OFS: prdata <= {30'h0000_0000, !link.final_sample_start_n, ready_r};
                    `CIS_RESULT_OFS: prdata <= 32'(result_r);
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    //--------------------------------------------------------------
    // Strobe generator
    //--------------------------------------------------------------
    logic [23:0] cnt_r;
    logic [23:0] min_period;
    logic [23:0] period_eff;
    logic [15:0] pulse_cap;
    logic [15:0] pulse_eff;

    always_comb
    begin
        min_period = ctrl_r[`CIS_CTRL_BIP] ? 24'(`CIS_MIN_BIP_CLK) : 24'(`CIS_MIN_UNI_CLK);
        period_eff = (period_r < min_period) ? min_period : period_r;
        pulse_cap = (os_r > 9'h001) ? 16'(os_r - 9'h001) : 16'h0001;
        pulse_eff = (pulse_r == 16'h0000) ? 16'h0001 : pulse_r;
        if (ctrl_r[`CIS_CTRL_CONT] && (pulse_eff > pulse_cap))
        begin
            pulse_eff = pulse_cap;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= 24'h00_0000;
            link.final_sample_start_n <= 1'b1;
        end
        else if (!ctrl_r[`CIS_CTRL_RUN])
        begin
            cnt_r <= 24'h00_0000;
            link.final_sample_start_n <= 1'b1;
        end
        else
        begin
            cnt_r <= (cnt_r >= period_eff - 24'h00_0001) ? 24'h00_0000 : cnt_r + 24'h00_0001;
            link.final_sample_start_n <= !(cnt_r < {8'h00, pulse_eff});
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            link.continuous <= 1'b0;
            link.cds_enable <= 1'b0;
            link.bipolar <= 1'b0;
            link.twos_complement <= 1'b0;
            link.acq_clocks <= `CIS_ACQ_DEF;
            link.oversample_count <= `CIS_OS_DEF;
        end
        else
        begin
            link.continuous <= ctrl_r[`CIS_CTRL_CONT];
            link.cds_enable <= ctrl_r[`CIS_CTRL_CDS];
            link.bipolar <= ctrl_r[`CIS_CTRL_BIP];
            link.twos_complement <= ctrl_r[`CIS_CTRL_TWOS]
                || (ctrl_r[`CIS_CTRL_BIP] && ctrl_r[`CIS_CTRL_CDS]);
            link.acq_clocks <= acq_r;
            link.oversample_count <= os_r;
        end
    end
endmodule : cis_controller
`default_nettype wire

// ==== cis_device.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cis_cfg.svh"
module cis_device
    import cis_pkg::*;
#(
    parameter int SW = `CIS_SAMPLE_W,
    parameter int RW = `CIS_RESULT_W,
    parameter logic [RW-1:0] FS_CODE = `CIS_FS_CODE
)
(
    input wire logic pclk,
    input wire logic presetn,
    cis_link_if.device link,
    input wire logic [SW-1:0] sample_data,
    output logic integ_reset,
    output logic [SW-1:0] track_rate,
    output logic [5:0] phase
);
    //--------------------------------------------------------------
    // Parameter checks
    //--------------------------------------------------------------
    // Sums of up to 511 samples need nine guard bits
    localparam int AW = SW + 9;

    if (RW < SW + 2)
    begin : g_bad_width
        $error("Result width too small for range");
    end

    //--------------------------------------------------------------
    // Strobe synchroniser and edges
    //--------------------------------------------------------------
    logic fds_meta_r;
    logic fds_sync_r;
    logic fds_prev_r;
    logic fds_active;
    logic fds_fall;
    logic fds_rise;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fds_meta_r <= 1'b1;
            fds_sync_r <= 1'b1;
            fds_prev_r <= 1'b1;
        end
        else
        begin
            fds_meta_r <= link.final_sample_start_n;
            fds_sync_r <= fds_meta_r;
            fds_prev_r <= fds_sync_r;
        end
    end

    assign fds_active = !fds_sync_r;
    assign fds_fall = fds_prev_r && !fds_sync_r;
    assign fds_rise = !fds_prev_r && fds_sync_r;

    //--------------------------------------------------------------
    // Sequencer
    //--------------------------------------------------------------
    cis_phase_type state_r;
    logic [8:0] cnt_r;
    logic [7:0] acq_len;
    logic [8:0] os_len;
    logic final_done;

    assign acq_len = (link.acq_clocks == 8'h00) ? 8'h01 : link.acq_clocks;
    assign os_len = (link.oversample_count == 9'h000) ? 9'h001 : link.oversample_count;
    assign final_done = (state_r == CIS_FINAL) && (cnt_r == os_len - 9'h001);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= CIS_WAIT;
            cnt_r <= 9'h000;
        end
        else
        begin
            case (state_r)
                CIS_WAIT:
                begin
                    cnt_r <= 9'h000;
                    if (fds_rise)
                    begin
                        state_r <= CIS_ACQ;
                    end
                end
                CIS_ACQ:
                begin
                    if (cnt_r == {1'b0, acq_len} - 9'h001)
                    begin
                        cnt_r <= 9'h000;
                        state_r <= CIS_INIT;
                    end
                    else
                    begin
                        cnt_r <= cnt_r + 9'h001;
                    end
                end
                CIS_INIT:
                begin
                    if (cnt_r == os_len - 9'h001)
                    begin
                        cnt_r <= 9'h000;
                        state_r <= CIS_TRACK;
                    end
                    else
                    begin
                        cnt_r <= cnt_r + 9'h001;
                    end
                end
                CIS_TRACK:
                begin
                    cnt_r <= 9'h000;
                    if (fds_fall)
                    begin
                        state_r <= CIS_FINAL;
                    end
                end
                CIS_FINAL:
                begin
                    if (final_done)
                    begin
                        cnt_r <= 9'h000;
                        if (fds_active)
                        begin
                            state_r <= CIS_HOLD;
                        end
                        else if (link.continuous)
                        begin
                            state_r <= CIS_ACQ;
                        end
                        else
                        begin
                            state_r <= CIS_WAIT;
                        end
                    end
                    else
                    begin
                        cnt_r <= cnt_r + 9'h001;
                    end
                end
                CIS_HOLD:
                begin
                    cnt_r <= 9'h000;
                    if (!fds_active)
                    begin
                        state_r <= CIS_ACQ;
                    end
                end
                default:
                begin
                    state_r <= CIS_WAIT;
                    cnt_r <= 9'h000;
                end
            endcase
        end
    end

    //--------------------------------------------------------------
    // Integrator reset
    //--------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            integ_reset <= 1'b1;
        end
        else
        begin
            case (state_r)
                CIS_WAIT: integ_reset <= !fds_rise;
                CIS_HOLD: integ_reset <= fds_active;
                CIS_FINAL: integ_reset <= final_done;
                default: integ_reset <= 1'b0;
            endcase
        end
    end

    //--------------------------------------------------------------
    // Integration rate memory
    //--------------------------------------------------------------
    logic [SW-1:0] prev_sample_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_sample_r <= '0;
            track_rate <= '0;
        end
        else
        begin
            prev_sample_r <= sample_data;
            if (state_r == CIS_HOLD)
            begin
                track_rate <= '0;
            end
            else if (state_r == CIS_TRACK)
            begin
                track_rate <= sample_data - prev_sample_r;
            end
        end
    end

    //--------------------------------------------------------------
    // Oversampled point accumulators
    //--------------------------------------------------------------
    logic signed [AW-1:0] sample_ext;
    logic signed [AW-1:0] init_sum_r;
    logic signed [AW-1:0] final_sum_r;

    assign sample_ext = {{(AW-SW){sample_data[SW-1]}}, sample_data};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            init_sum_r <= '0;
            final_sum_r <= '0;
        end
        else
        begin
            if (state_r == CIS_ACQ)
            begin
                init_sum_r <= '0;
            end
            else if (state_r == CIS_INIT)
            begin
                init_sum_r <= init_sum_r + sample_ext;
            end
            if (state_r == CIS_TRACK)
            begin
                final_sum_r <= '0;
            end
            else if (state_r == CIS_FINAL)
            begin
                final_sum_r <= final_sum_r + sample_ext;
            end
        end
    end

    //--------------------------------------------------------------
    // Result: correction, range clamp, encoding
    //--------------------------------------------------------------
    logic signed [AW-1:0] final_full;
    logic signed [AW-1:0] raw;
    logic signed [AW-1:0] hi_lim;
    logic signed [AW-1:0] lo_lim;
    logic signed [AW-1:0] clamped;
    logic [RW-1:0] encoded;

    always_comb
    begin
        final_full = final_sum_r + sample_ext;
        raw = link.cds_enable ? (final_full - init_sum_r) : final_full;
        if (link.bipolar)
        begin
            hi_lim = signed'(AW'(FS_CODE >> 1));
            lo_lim = -signed'(AW'((FS_CODE >> 1) + (FS_CODE >> 8)));
        end
        else
        begin
            hi_lim = signed'(AW'(FS_CODE));
            lo_lim = -signed'(AW'(FS_CODE >> 8));
        end
        if (raw > hi_lim)
        begin
            clamped = hi_lim;
        end
        else if (raw < lo_lim)
        begin
            clamped = lo_lim;
        end
        else
        begin
            clamped = raw;
        end
        encoded = RW'(link.twos_complement ? clamped : (clamped - lo_lim));
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            link.result <= '0;
            link.result_valid <= 1'b0;
            link.tracking <= 1'b0;
            phase <= 6'h01;
        end
        else
        begin
            link.result_valid <= final_done;
            if (final_done)
            begin
                link.result <= encoded;
            end
            link.tracking <= (state_r == CIS_TRACK);
            phase <= state_r;
        end
    end
endmodule : cis_device
`default_nettype wire

// ==== cis_link_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module cis_link_chk #(parameter int RW = 24)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic final_sample_start_n,
    input wire logic continuous,
    input wire logic cds_enable,
    input wire logic bipolar,
    input wire logic twos_complement,
    input wire logic [7:0] acq_clocks,
    input wire logic [8:0] oversample_count,
    input wire logic [RW-1:0] result,
    input wire logic result_valid,
    input wire logic tracking
);
    // ----
    // Cycle counters
    // ----
    logic [11:0] fall_cnt_r;
    logic [11:0] rv_cnt_r;
    logic [11:0] low_cnt_r;
    logic armed_r;
    logic [11:0] m_eff;
    logic [11:0] km;
    assign m_eff = (oversample_count == 9'h000) ? 12'h001 : {3'h0, oversample_count};
    assign km = m_eff + ((acq_clocks == 8'h00) ? 12'h001 : {4'h0, acq_clocks});

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fall_cnt_r <= 12'hFFF;
            rv_cnt_r <= 12'hFFF;
            low_cnt_r <= 12'h000;
            armed_r <= 1'b0;
        end
        else
        begin
            fall_cnt_r <= $fell(final_sample_start_n) ? 12'h000 :
                fall_cnt_r + {11'h000, fall_cnt_r != 12'hFFF};
            rv_cnt_r <= result_valid ? 12'h000 : rv_cnt_r + {11'h000, rv_cnt_r != 12'hFFF};
            low_cnt_r <= final_sample_start_n ? 12'h000 : low_cnt_r + 12'h001;
            armed_r <= (result_valid && continuous && final_sample_start_n) ||
                (armed_r && continuous && !$rose(tracking));
        end
    end

    // ----
    // Properties
    // ----
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_valid_pulse: assert property (result_valid |=> !result_valid)
        else $error("result_valid wider than one cycle");
    chk_result_hold: assert property (!result_valid |-> $stable(result))
        else $error("result changed without result_valid");
    chk_final_time: assert property (result_valid |->
        fall_cnt_r >= m_eff + 12'h001 && fall_cnt_r <= m_eff + 12'h004)
        else $error("result not oversample_count clocks after strobe");
    chk_track_end: assert property ($fell(final_sample_start_n) && tracking |->
        ##[1:6] !tracking)
        else $error("tracking did not end after strobe");
    chk_cont_restart: assert property ($rose(tracking) && armed_r |->
        rv_cnt_r + 12'h002 >= km && rv_cnt_r <= km + 12'h001)
        else $error("continuous restart timing wrong");
    chk_pulse_short: assert property (!final_sample_start_n && continuous &&
        m_eff > 12'h001 |-> low_cnt_r + 12'h001 < m_eff)
        else $error("continuous strobe too long");
    chk_min_period: assert property ($fell(final_sample_start_n) |->
        fall_cnt_r >= (bipolar ? 12'h27F : 12'h4FF))
        else $error("integration shorter than minimum");
    chk_cds_twos: assert property (bipolar && cds_enable |-> twos_complement)
        else $error("bipolar correction without twos complement");
    chk_range_twos: assert property (result_valid && twos_complement |->
        $signed(result) >= (bipolar ? -32'sh0004_0800 : -32'sh0000_0800) &&
        $signed(result) <= (bipolar ? 32'sh0004_0000 : 32'sh0008_0000))
        else $error("signed result out of range");
    chk_range_bin: assert property (result_valid && !twos_complement |->
        result <= 24'h08_0800)
        else $error("binary result out of range");
endmodule : cis_link_chk
`default_nettype wire

// ==== cis_link_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface cis_link_if #(parameter int RW = 24);
    logic final_sample_start_n;
    logic continuous;
    logic cds_enable;
    logic bipolar;
    logic twos_complement;
    logic [7:0] acq_clocks;
    logic [8:0] oversample_count;
    logic [RW-1:0] result;
    logic result_valid;
    logic tracking;

    modport device (
        input final_sample_start_n,
        input continuous,
        input cds_enable,
        input bipolar,
        input twos_complement,
        input acq_clocks,
        input oversample_count,
        output result,
        output result_valid,
        output tracking
    );

    modport controller (
        output final_sample_start_n,
        output continuous,
        output cds_enable,
        output bipolar,
        output twos_complement,
        output acq_clocks,
        output oversample_count,
        input result,
        input result_valid,
        input tracking
    );
endinterface : cis_link_if
`default_nettype wire

// ==== cis_pkg.sv ====
package cis_pkg;
    typedef enum logic [5:0] {
        CIS_WAIT = 6'b00_0001,
        CIS_ACQ = 6'b00_0010,
        CIS_INIT = 6'b00_0100,
        CIS_TRACK = 6'b00_1000,
        CIS_FINAL = 6'b01_0000,
        CIS_HOLD = 6'b10_0000
    } cis_phase_type;
endpackage : cis_pkg

// ==== tb_charge_integration_sequencer.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_charge_integration_sequencer;
    logic pclk = 1'b0;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [19:0] sample_data;
    logic [31:0] rdat;
    logic err;
    logic integ_reset;
    logic [5:0] phase;
    int num_errors = 0;
    int comparisons = 0;

    cis_link_if #(.RW(24)) u_cis_link_if ();
    cis_device u_cis_device (.pclk(pclk), .presetn(presetn), .link(u_cis_link_if),
        .sample_data(sample_data), .integ_reset(integ_reset), .track_rate(), .phase(phase));
    cis_controller u_cis_controller (.pclk(pclk), .presetn(presetn), .link(u_cis_link_if),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    cis_link_chk #(.RW(24)) u_cis_link_chk (.pclk(pclk), .presetn(presetn),
        .final_sample_start_n(u_cis_link_if.final_sample_start_n),
        .continuous(u_cis_link_if.continuous), .cds_enable(u_cis_link_if.cds_enable),
        .bipolar(u_cis_link_if.bipolar), .twos_complement(u_cis_link_if.twos_complement),
        .acq_clocks(u_cis_link_if.acq_clocks), .oversample_count(u_cis_link_if.oversample_count),
        .result(u_cis_link_if.result), .result_valid(u_cis_link_if.result_valid),
        .tracking(u_cis_link_if.tracking));

    initial
    begin
        forever #25 pclk = ~pclk;
    end

    // ----
    // Bus and compare tasks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0000_0000, d, e);
    endtask : rd

    task automatic get_result(output logic [31:0] d);
        logic [31:0] s;
        int n;
        s = 32'h0000_0000;
        n = 0;
        while (s[0] !== 1'b1)
        begin
            rd(12'h010, s);
            n++;
        end
        rd(12'h014, d);
    endtask : get_result

    // Ctrl bits: cont, cds, bipolar, twos above run
    task automatic run_case(input logic [4:0] ctrl, input logic [7:0] acq,
                            input logic [8:0] os, input logic [19:0] s, input logic [23:0] exp);
        logic [31:0] r;
        sample_data <= s;
        wr(12'h004, {7'h00, os, 8'h00, acq});
        rd(12'h014, r);
        wr(12'h000, {27'h000_0000, ctrl | 5'h01});
        get_result(r);
        get_result(r);
        check({8'h00, r[23:0]}, {8'h00, exp});
        check({8'h00, u_cis_link_if.result}, {8'h00, exp});
        wr(12'h000, 32'h0000_0000);
        repeat (1300) @(posedge pclk);
        check({31'h0000_0000, integ_reset}, {31'h0000_0000, !ctrl[1]});
        check({26'h000_0000, phase}, ctrl[1] ? 32'h0000_0008 : 32'h0000_0001);
    endtask : run_case

    task automatic print_verdict();
        $display("Comparisons %0d, errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    initial
    begin
        repeat (90000) @(posedge pclk);
        num_errors++;
        print_verdict();
    end

    // ----
    // Test sequence
    // ----
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        sample_data = 20'h0_0000;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h000, rdat);
        check(rdat, 32'h0000_0000);
        rd(12'h004, rdat);
        check(rdat, 32'h0010_0010);
        rd(12'h008, rdat);
        check(rdat, 32'h0000_2710);
        rd(12'h00C, rdat);
        check(rdat, 32'h0000_0004);
        apb(1'b0, 12'h020, 32'h0000_0000, rdat, err);
        check(rdat, 32'h0000_0000);
        check(32'(err), 32'h0000_0001);
        wr(12'h010, 32'hFFFF_FFFF);
        rd(12'h010, rdat);
        check(rdat, 32'h0000_0000);
        wr(12'h008, 32'h0000_0064);
        run_case(5'h12, 8'h10, 9'h010, 20'h0_0100, 24'h00_1000);
        run_case(5'h10, 8'h10, 9'h020, 20'h0_0100, 24'h00_2000);
        run_case(5'h02, 8'h10, 9'h010, 20'h0_0100, 24'h00_1800);
        run_case(5'h12, 8'h10, 9'h010, 20'hF_FF00, 24'hFF_F800);
        run_case(5'h12, 8'h10, 9'h010, 20'h1_0000, 24'h08_0000);
        run_case(5'h1A, 8'h10, 9'h010, 20'h0_8000, 24'h04_0000);
        run_case(5'h1A, 8'h10, 9'h010, 20'hF_8000, 24'hFB_F800);
        run_case(5'h0A, 8'h10, 9'h010, 20'h0_0100, 24'h04_1800);
        run_case(5'h16, 8'h05, 9'h010, 20'h1_2345, 24'h00_0000);
        run_case(5'h06, 8'h10, 9'h010, 20'h0_1234, 24'h00_0800);
        run_case(5'h0E, 8'h10, 9'h010, 20'h0_1234, 24'h00_0000);
        run_case(5'h14, 8'h10, 9'h010, 20'h0_1234, 24'h00_0000);
        run_case(5'h12, 8'h00, 9'h000, 20'h0_0100, 24'h00_0100);
        print_verdict();
    end
endmodule : tb_charge_integration_sequencer
`default_nettype wire
